/* File: line_logic_inhibit_panel.sv */
// Gating of line terminal halves by operator switches, with activity lamps.
// Assumes each half raises xfer_req while it has a character to move and a
// per-half command strobe; grant lasts one cycle per character.
`timescale 1ns/100ps
`default_nettype none
module line_logic_inhibit_panel
	import line_panel_pkg::*;
#(
	parameter int LINES = LINES_FOUR,
	parameter int HALVES = LINES * HALVES_PER_LINE,
	parameter int DIALERS = (LINES + LINES_PER_DIALER - 1) / LINES_PER_DIALER
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire logic              offline_sw_n,
	input  wire logic [HALVES-1:0] enable_sw,
	input  wire logic [LINES-1:0]  half_duplex,
	input  wire logic [HALVES-1:0] xfer_req,
	input  wire logic [HALVES-1:0] xfer_done,
	input  wire logic [HALVES-1:0] cmd_valid,
	input  wire logic              poll,
	input  wire logic [DIALERS-1:0] dial_req,
	output var  logic [HALVES-1:0] xfer_grant,
	output var  logic [HALVES-1:0] activity_lamp,
	output var  logic [DIALERS-1:0] dial_lamp,
	output var  logic [DIALERS-1:0] dial_enable,
	output var  logic [HALVES-1:0] status_valid,
	output var  logic [7:0]        status_byte,
	output var  logic              poll_ack,
	output var  logic              online
);
	logic [HALVES-1:0] en_sync;
	logic              online_sync;
	logic [HALVES-1:0] en_r;
	logic              online_r;
	logic [HALVES-1:0] busy_r;
	logic [HALVES-1:0] eligible;
	logic [HALVES-1:0] grant_nxt;
	logic              any_busy;

	// Slots of the highest-priority line, used by the pairwise checks
	localparam int TOP_IN  = HALVES - HALVES_PER_LINE + HALF_IN;
	localparam int TOP_OUT = HALVES - HALVES_PER_LINE + HALF_OUT;

	for (genvar h = 0; h < HALVES; h++) begin : g_sync
		switch_sync u_sync (
			.core_clk (core_clk),
			.rst      (rst),
			.sw_in    (enable_sw[h]),
			.sw_out   (en_sync[h])
		);
	end
	switch_sync u_offline (
		.core_clk (core_clk),
		.rst      (rst),
		.sw_in    (offline_sw_n),
		.sw_out   (online_sync)
	);

	assign any_busy = |busy_r;

	// A half may start only if enabled, online, and its half-duplex partner is idle
	always_comb begin
		eligible = '0;
		for (int h = 0; h < HALVES; h++) begin
			eligible[h] = xfer_req[h] && en_r[h] && online_r && !busy_r[h] &&
				!(half_duplex[h/HALVES_PER_LINE] && busy_r[h ^ 1]);
		end
	end

	// Later lines overwrite earlier ones, so the highest line wins; within a line
	// the else-if lets the input half outrank the output half
	always_comb begin
		grant_nxt = '0;
		for (int l = 0; l < LINES; l++) begin
			if (eligible[HALVES_PER_LINE*l + HALF_IN]) begin
				grant_nxt = '0;
				grant_nxt[HALVES_PER_LINE*l + HALF_IN] = 1'b1;
			end else if (eligible[HALVES_PER_LINE*l + HALF_OUT]) begin
				grant_nxt = '0;
				grant_nxt[HALVES_PER_LINE*l + HALF_OUT] = 1'b1;
			end
		end
	end

	// Switch state latched only when no half is mid-character
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			en_r     <= '0;
			online_r <= 1'b0;
		end else if (!any_busy && !(|cmd_valid)) begin
			en_r     <= en_sync;
			online_r <= online_sync;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_r        <= '0;
			xfer_grant    <= '0;
			activity_lamp <= '0;
		end else begin
			busy_r        <= (busy_r & ~xfer_done) | grant_nxt;
			xfer_grant    <= grant_nxt;
			activity_lamp <= (busy_r & ~xfer_done) | grant_nxt;
		end
	end

	// Each dialer rides on the lowest-priority output half of its group
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dial_enable <= '0;
			dial_lamp   <= '0;
		end else begin
			for (int d = 0; d < DIALERS; d++) begin
				dial_enable[d] <= en_r[HALVES_PER_LINE*LINES_PER_DIALER*d + HALF_OUT]
					&& online_r;
				dial_lamp[d]   <= dial_req[d] && online_r
					&& en_r[HALVES_PER_LINE*LINES_PER_DIALER*d + HALF_OUT];
			end
		end
	end

	// Commands always answered while online; inhibited halves flag exception
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			status_valid <= '0;
			status_byte  <= STATUS_OK;
			poll_ack     <= 1'b0;
			online       <= 1'b0;
		end else begin
			status_valid <= cmd_valid & {HALVES{online_r}};
			status_byte  <= STATUS_OK;
			for (int h = 0; h < HALVES; h++) begin
				if (cmd_valid[h] && !en_r[h])
					status_byte[EXCEPTION_BIT] <= 1'b1;
			end
			poll_ack <= poll && online_r;
			online   <= online_r;
		end
	end

	ack_offline_a: assert property (@(posedge core_clk) disable iff (rst)
		!online_r |-> ##1 !poll_ack) else $error("poll answered while offline");
	exc_inhibit_a: assert property (@(posedge core_clk) disable iff (rst)
		(cmd_valid[0] && !en_r[0] && online_r && $onehot(cmd_valid))
		|-> ##1 status_byte[EXCEPTION_BIT]) else $error("no exception");
	no_grant_inh_a: assert property (@(posedge core_clk) disable iff (rst)
		(xfer_grant & ~$past(en_r)) == '0) else $error("inhibited half granted");
	grant_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
		$onehot0(xfer_grant)) else $error("several grants");
	lamp_busy_a: assert property (@(posedge core_clk) disable iff (rst)
		activity_lamp == busy_r) else $error("lamp differs from activity");
	// The top line always wins, so both of its halves eligible must go to the input
	sequence top_both_s;
		eligible[TOP_IN] && eligible[TOP_OUT];
	endsequence
	sequence top_in_won_s;
		xfer_grant[TOP_IN] && !xfer_grant[TOP_OUT];
	endsequence
	pri_in_a: assert property (@(posedge core_clk) disable iff (rst)
		top_both_s |-> ##1 top_in_won_s) else $error("out beat in");
	duplex_pair_a: assert property (@(posedge core_clk) disable iff (rst)
		half_duplex[LINES-1] |-> !(activity_lamp[TOP_IN] && activity_lamp[TOP_OUT]))
		else $error("both lamps lit");
	dial_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		!en_r[HALF_OUT] |-> ##1 !dial_enable[0]) else $error("dialer alive");
	dial_source_a: assert property (@(posedge core_clk) disable iff (rst)
		dial_enable[0] |-> ($past(en_r[HALF_OUT]) && $past(online_r)))
		else $error("dialer without its output half");
	status_off_a: assert property (@(posedge core_clk) disable iff (rst)
		!online_r |-> ##1 (status_valid == '0)) else $error("status sent while offline");
	// Latched switch state must not move under a character or a command
	stable_mid_a: assert property (@(posedge core_clk) disable iff (rst)
		(any_busy || (|cmd_valid)) |-> ##1 ($stable(en_r) && $stable(online_r)))
		else $error("switch applied mid-transfer");

	// Per-half checks: exception reply, lamp tracking and line priority
	for (genvar g = 0; g < HALVES; g++) begin : g_half_chk
		sequence cmd_inhibited_s;
			cmd_valid[g] && !en_r[g] && online_r;
		endsequence
		sequence exc_reply_s;
			status_valid[g] && status_byte[EXCEPTION_BIT];
		endsequence
		exc_half_a: assert property (@(posedge core_clk) disable iff (rst)
			cmd_inhibited_s |-> ##1 exc_reply_s)
			else $error("inhibited half answered clean");
		lamp_grant_a: assert property (@(posedge core_clk) disable iff (rst)
			xfer_grant[g] |-> activity_lamp[g]) else $error("granted half dark");
		lamp_off_a: assert property (@(posedge core_clk) disable iff (rst)
			(activity_lamp[g] && xfer_done[g] && !grant_nxt[g]) |-> ##1 !activity_lamp[g])
			else $error("lamp lit after done");
		// Any eligible half on a higher line must take the grant instead
		pri_line_a: assert property (@(posedge core_clk) disable iff (rst)
			(eligible[g] && ((eligible >> (HALVES_PER_LINE * (g / HALVES_PER_LINE + 1))) != '0))
			|-> ##1 !xfer_grant[g]) else $error("lower line granted");
	end

	// Half-duplex pairs, line by line; a duplex change under load is not covered
	for (genvar l = 0; l < LINES; l++) begin : g_line_chk
		duplex_line_a: assert property (@(posedge core_clk) disable iff (rst)
			(half_duplex[l] && $stable(half_duplex[l]))
			|-> !(activity_lamp[HALVES_PER_LINE*l + HALF_IN]
				&& activity_lamp[HALVES_PER_LINE*l + HALF_OUT]))
			else $error("duplex pair both lit");
	end
endmodule
`default_nettype wire

/* File: line_panel_pkg.sv */
// Constants and types for the line inhibit panel logic.
// Assumes a single core clock; switches arrive asynchronously from the panel.
// Behaviour
// - Single-line input disable down: receive half idle, commands answered with exception.
// - Single-line output disable down: transmit half idle, commands answered with exception.
// - Offline switch down: whole subsystem offline, every channel poll ignored.
// - Multi-line: each half has its own inhibit; inhibited half moves nothing, answers exception.
// - Activity lamp lit exactly while its half is moving data.
// - Terminals served by fixed priority, rightmost (highest index) highest.
// - Within a terminal, input half outranks output half.
// - Half-duplex terminal never shows both lamps of its pair lit.
// - Dialing adapter has no inhibit; idle whenever lowest-priority output half is inhibited.
// - Four-line variant: eight inhibit switches, nine activity lamps.
// - Sixteen-line variant: 32 halves, four dialing adapters, 36 lamps, 32 switches.
package line_panel_pkg;
	localparam int LINES_FOUR       = 4;
	localparam int LINES_SIXTEEN    = 16;
	localparam int HALVES_PER_LINE  = 2;
	localparam int LINES_PER_DIALER = 4;
	localparam int SYNC_STAGES      = 3;
	localparam int HALF_IN          = 0;
	localparam int HALF_OUT         = 1;
	localparam logic [7:0] STATUS_OK        = 8'h00;
	localparam int         EXCEPTION_BIT    = 0;
	typedef enum logic [1:0] {
		HALF_IDLE,
		HALF_CMD,
		HALF_XFER
	} half_state_e;
endpackage

/* File: switch_sync.sv */
// Three-stage synchroniser for one panel switch.
// Assumes the switch is a slow level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module switch_sync
	import line_panel_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic sw_in,
	output var  logic sw_out
);
	logic [SYNC_STAGES-1:0] stage_r;

	// Change taken only once the second and third stages agree
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage_r <= '0;
			sw_out  <= 1'b0;
		end else begin
			stage_r <= {stage_r[SYNC_STAGES-2:0], sw_in};
			if (stage_r[SYNC_STAGES-1] == stage_r[SYNC_STAGES-2])
				sw_out <= stage_r[SYNC_STAGES-1];
		end
	end
endmodule
`default_nettype wire

/* File: channel_model.sv */
// Processor channel stand-in: issues single-cycle polls on request.
// Assumes the bench raises poll_go for one cycle per poll wanted.
`timescale 1ns/100ps
`default_nettype none
module channel_model (
	input  wire logic core_clk,
	input  wire logic poll_go,
	output var  logic poll
);
	// Polls are retimed to the clock so the panel never sees a runt
	always_ff @(posedge core_clk) poll <= poll_go;
endmodule
`default_nettype wire

/* File: test_line_logic_inhibit_panel.sv */
// Bench for the line inhibit panel, four-line build: grants, status, polls.
// Assumes one core clock; expected status comes from the package constants, expected grants, lamps and counts are literals.
`timescale 1ns/100ps
`default_nettype none
module test_line_logic_inhibit_panel;
	import line_panel_pkg::*;
	localparam int H = LINES_FOUR * HALVES_PER_LINE;
	logic            core_clk = 0, rst = 1, offline_sw_n = 1, poll_go = 0, poll, ack, online;
	logic [H-1:0]    enable_sw = '1, xfer_req = '0, xfer_done = '0, cmd_valid = '0;
	logic [H-1:0]    grant, lamp, stat_v;
	logic [3:0]      half_duplex = '0;
	logic [0:0]      dial_req = '0, dial_lit, dial_on;
	logic [7:0]      stat;
	logic [7:0]      stat_q[$], grant_q[$], vld_q[$];
	int              err_total = 0, cmp_count = 0, acks = 0, h;
	channel_model channel_model_i (.core_clk(core_clk), .poll_go(poll_go), .poll(poll));
	line_logic_inhibit_panel #(.LINES(LINES_FOUR)) line_logic_inhibit_panel_i (
		.core_clk(core_clk), .rst(rst), .offline_sw_n(offline_sw_n),
		.enable_sw(enable_sw), .half_duplex(half_duplex), .xfer_req(xfer_req),
		.xfer_done(xfer_done), .cmd_valid(cmd_valid), .poll(poll), .dial_req(dial_req),
		.xfer_grant(grant), .activity_lamp(lamp), .dial_lamp(dial_lit), .dial_enable(dial_on),
		.status_valid(stat_v), .status_byte(stat), .poll_ack(ack), .online(online));
	initial forever #2.5 core_clk = ~core_clk;
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// An unexpected result meets an unknown note and so always mismatches
	task automatic chk_grant(input logic [7:0] g);
		cmp(g, grant_q.size() ? grant_q.pop_front() : 8'hxx);
	endtask
	task automatic chk_stat(input logic [7:0] s);
		cmp(s, stat_q.size() ? stat_q.pop_front() : 8'hxx);
	endtask
	task automatic chk_vld(input logic [7:0] v);
		cmp(v, vld_q.size() ? vld_q.pop_front() : 8'hxx);
	endtask
	always @(posedge core_clk) begin
		if (grant !== '0) chk_grant(grant);
		if (stat_v !== '0) begin
			chk_stat(stat);
			chk_vld(stat_v);
		end
		if (ack === 1'b1) acks++;
	end
	// Each granted half is finished one cycle later and its request dropped
	task automatic move(input logic [7:0] req, input logic [7:0] e1, input logic [7:0] e2);
		grant_q.push_back(e1);
		grant_q.push_back(e2);
		xfer_req <= req;
		repeat (20) begin
			cyc(1);
			xfer_done <= (grant === '0) ? '0 : grant;
			xfer_req <= xfer_req & ~grant;
		end
		cmp(lamp, 8'h00);
	endtask
	task automatic command(input int k, input logic [7:0] exp);
		stat_q.push_back(exp);
		vld_q.push_back(8'h01 << k);
		cmd_valid[k] <= 1'b1;
		cyc(1);
		cmd_valid <= '0;
		cyc(6);
	endtask
	task automatic report_and_stop;
		$display("compares %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		err_total++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'h46a5));
		h = $urandom % H;
		cyc(2);
		rst <= 1'b0;
		cyc(6);
		poll_go <= 1'b1;
		cyc(1);
		poll_go <= 1'b0;
		half_duplex <= '1;
		move(8'hc0, 8'h40, 8'h80);
		move(8'h24, 8'h20, 8'h04);
		enable_sw[h] <= 1'b0;
		cyc(8);
		xfer_req[h] <= 1'b1;
		command(h, STATUS_OK | (8'h01 << EXCEPTION_BIT));
		xfer_req <= '0;
		command((h + 1) % H, STATUS_OK);
		dial_req <= 1'b1;
		cyc(3);
		cmp({6'h00, dial_lit, dial_on}, (h == HALF_OUT) ? 8'h00 : 8'h03);
		offline_sw_n <= 1'b0;
		cyc(8);
		poll_go <= 1'b1;
		cyc(1);
		poll_go <= 1'b0;
		cyc(4);
		cmp({7'h00, online}, 8'h00);
		cmp({6'h00, dial_lit, dial_on}, 8'h00);
		cmp(8'(acks), 8'h01);
		report_and_stop;
	end
endmodule
`default_nettype wire
